// File: design/csd_regs.svh
// constants of the chip-select and idle-cycle decoder
`ifndef CSD_REGS_SVH
`define CSD_REGS_SVH

// select positions inside the select vector
`define CSD_NUM_SEL        6
`define CSD_SEL_BOOT       0
`define CSD_SEL_GEN_A      1
`define CSD_SEL_GEN_B      2
`define CSD_SEL_PERIPH     3
`define CSD_SEL_DRAM       4
`define CSD_SEL_NONCACHE   5

// reset values
`define CSD_ENABLE_RST     6'h01
`define CSD_BOOT_BASE      28'h0000000

// peripheral area spans 1 Kbyte: bits below this position are free
`define CSD_PERIPH_LSB     10
`define CSD_PERIPH_MASK    28'hffffc00

// system support control bit positions
`define CSD_SSC_DRAM_EN    6
`define CSD_SSC_BURST_EN   7

// bus width codes
`define CSD_WIDTH_8        2'h0
`define CSD_WIDTH_16       2'h1
`define CSD_WIDTH_32       2'h2

// idle cycles, in input clock periods
`define CSD_IDLE_RD_WR     2'h1
`define CSD_IDLE_BOOT      2'h2
`define CSD_IDLE_DRAM_WR   2'h1

// dram page size: 256 columns shifted by a code of 0 to 4 (4096 columns)
`define CSD_PAGE_COL_BITS  4'h8
`define CSD_PAGE_CODE_MAX  3'h4

`endif

// File: design/csd_pkg.sv
// types of the chip-select and idle-cycle decoder
package csd_pkg;

   // settings of one chip select
   typedef struct packed {
      logic [27:0] base;       // address_range_setting
      logic [27:0] mask;       // address_mask_setting, 1 = bit compared
      logic [1:0]  width;      // bus width code
      logic        wait_en;    // wait generator enable
      logic [3:0]  waits;      // wait states when enabled
   } csd_sel_cfg_t;

   // one bus cycle request from the bus interface unit
   typedef struct packed {
      logic        valid;
      logic [27:0] addr;
      logic        write;
      logic        ifetch;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
   } csd_bus_req_t;

   typedef enum logic [1:0] {
      CSD_ST_IDLE,
      CSD_ST_GAP,
      CSD_ST_ACCESS
   } csd_state_t;

endpackage

// File: design/csd_decoder.sv
// chip-select decoder with wait-state and idle-cycle insertion
// ==========================================================================
// Summary of operation
// - six chip selects, each with its own wait-state generator; ranges kept apart by software
// - boot ROM select has fixed base 0; first fetch comes from address 0
// - after reset only boot ROM select is enabled; others wait for software
// - peripheral select area is limited to one 1 Kbyte range
// - on-chip peripheral accesses drive address, strobes, ready and store data externally
// - peripheral area width is 16 or 32 bits; 8-bit setting is refused
// - DRAM select drives page-hit detection; page hit only for DRAM area
// - non-cacheable select is general purpose unless non-cache and DRAM controller on
// - non-cacheable range may overlap the DRAM area
// - with DRAM controller on, non-cacheable area uses the DRAM area width
// - idle pin low: one idle cycle when write follows read
// - idle pin high: two idle cycles after boot ROM unless next is boot ROM or an instruction fetch
// - DRAM: one idle cycle for data write after DRAM read or fetch only
// - DRAM controller enable is control bit 6, burst enable bit 7
// - DRAM page size 256 to 4096 columns; EDO only in burst mode
`timescale 1ns/1ns
`include "csd_regs.svh"

module csd_decoder (
   input  wire logic                   core_clk,
   input  wire logic                   sys_rst,
   input  wire csd_pkg::csd_bus_req_t  bus_req,
   output logic                        bus_busy,
   output logic                        bus_ack,
   input  wire csd_pkg::csd_sel_cfg_t  sel_cfg [`CSD_NUM_SEL],
   input  wire logic [`CSD_NUM_SEL-1:0] sel_enable,
   input  wire logic                   sel_enable_load,
   input  wire logic [27:0]            same_page_mask_setting,
   input  wire logic [7:0]             system_support_control,
   input  wire logic                   noncache_function_en,
   input  wire logic [2:0]             dram_page_code,
   input  wire logic                   dram_edo_select,
   input  wire logic                   idle_insert_select_pin,
   output logic                        boot_rom_select_n,
   output logic                        general_select_a_n,
   output logic                        general_select_b_n,
   output logic                        peripheral_register_select_n,
   output logic                        dram_select_n,
   output logic                        noncacheable_area_select_n,
   output logic [27:2]                 bus_addr,
   output logic                        address_strobe_n,
   output logic                        read_write_indicator,
   output logic [3:0]                  byte_enables_n,
   output logic                        ready_output_n,
   output logic [31:0]                 data_out,
   output logic                        data_out_en,
   output logic                        page_hit_indication_n,
   output logic                        cycle_noncacheable,
   output logic [1:0]                  cycle_width,
   output logic                        idle_cycle_active,
   output logic                        dram_ctrl_enable,
   output logic                        dram_burst_enable,
   output logic                        dram_edo_enable,
   output logic [3:0]                  dram_col_bits
);
   import csd_pkg::*;

   // ========================================================================
   // idle pin synchroniser
   logic idle_meta_q;
   logic idle_pin_q;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         idle_meta_q <= 1'b0;
         idle_pin_q  <= 1'b0;
      end else begin
         idle_meta_q <= idle_insert_select_pin;
         idle_pin_q  <= idle_meta_q;
      end
   end

   // ========================================================================
   // address decode of the incoming request
   logic                    dram_en;
   logic [`CSD_NUM_SEL-1:0] en_q;
   logic [`CSD_NUM_SEL-1:0] en_d;
   logic [`CSD_NUM_SEL-1:0] hit_c;
   logic [`CSD_NUM_SEL-1:0] sel_c;
   logic [27:0]             base_c;
   logic [27:0]             mask_c;
   logic [1:0]              width_c;
   logic [3:0]              waits_c;
   logic                    nc_c;

   assign dram_en = system_support_control[`CSD_SSC_DRAM_EN];

   always_comb begin
      en_d = en_q;
      if (sel_enable_load) begin
         en_d = sel_enable;
      end
   end

   always_comb begin
      hit_c = '0;
      for (int i = 0; i < `CSD_NUM_SEL; i++) begin
         base_c = sel_cfg[i].base;
         mask_c = sel_cfg[i].mask;
         if (i == `CSD_SEL_BOOT) begin
            base_c = `CSD_BOOT_BASE;
         end
         if (i == `CSD_SEL_PERIPH) begin
            mask_c = mask_c | `CSD_PERIPH_MASK;
         end
         hit_c[i] = en_q[i] && (((bus_req.addr ^ base_c) & mask_c) == 28'h0);
      end
   end

   // one select wins by position; only the dram/non-cacheable pair may share a cycle
   always_comb begin
      sel_c = '0;
      if (hit_c[`CSD_SEL_BOOT]) begin
         sel_c[`CSD_SEL_BOOT] = 1'b1;
      end else if (hit_c[`CSD_SEL_GEN_A]) begin
         sel_c[`CSD_SEL_GEN_A] = 1'b1;
      end else if (hit_c[`CSD_SEL_GEN_B]) begin
         sel_c[`CSD_SEL_GEN_B] = 1'b1;
      end else if (hit_c[`CSD_SEL_PERIPH]) begin
         sel_c[`CSD_SEL_PERIPH] = 1'b1;
      end else begin
         sel_c[`CSD_SEL_DRAM]     = hit_c[`CSD_SEL_DRAM];
         sel_c[`CSD_SEL_NONCACHE] = hit_c[`CSD_SEL_NONCACHE];
      end
   end

   // width and waits; dram settings govern a cycle inside the overlap
   always_comb begin
      width_c = `CSD_WIDTH_32;
      waits_c = 4'h0;
      for (int i = 0; i < `CSD_NUM_SEL; i++) begin
         if (sel_c[i] && !(i == `CSD_SEL_NONCACHE && sel_c[`CSD_SEL_DRAM])) begin
            width_c = sel_cfg[i].width;
            waits_c = sel_cfg[i].wait_en ? sel_cfg[i].waits : 4'h0;
         end
      end
      if (sel_c[`CSD_SEL_PERIPH] && width_c == `CSD_WIDTH_8) begin
         width_c = `CSD_WIDTH_16;
      end
      if (sel_c[`CSD_SEL_NONCACHE] && dram_en) begin
         width_c = sel_cfg[`CSD_SEL_DRAM].width;
      end
      nc_c = sel_c[`CSD_SEL_NONCACHE] && noncache_function_en && dram_en;
   end

   // ========================================================================
   // idle cycles owed between back-to-back cycles
   logic       prev_valid_q;
   logic       prev_write_q;
   logic       prev_boot_q;
   logic       prev_dram_q;
   logic [1:0] gap_c;

   always_comb begin
      gap_c = 2'h0;
      if (prev_valid_q) begin
         if (!idle_pin_q && !prev_write_q && bus_req.write) begin
            gap_c = `CSD_IDLE_RD_WR;
         end
         if (prev_dram_q && !prev_write_q && bus_req.write && sel_c[`CSD_SEL_DRAM]) begin
            gap_c = `CSD_IDLE_DRAM_WR;
         end
         if (idle_pin_q && prev_boot_q && !sel_c[`CSD_SEL_BOOT] && !bus_req.ifetch) begin
            gap_c = `CSD_IDLE_BOOT;
         end
      end
   end

   // ========================================================================
   // bus cycle sequencer
   csd_state_t              state_q, state_d;
   logic [1:0]              gap_q, gap_d;
   logic [3:0]              wait_q, wait_d;
   logic [`CSD_NUM_SEL-1:0] psel_q, psel_d;
   logic [`CSD_NUM_SEL-1:0] sel_n_q, sel_n_d;
   csd_bus_req_t            lat_q, lat_d;
   logic                    phit_q, phit_d;
   logic                    busy_q, busy_d;
   logic                    ack_q, ack_d;
   logic                    as_n_q, as_n_d;
   logic                    rdy_n_q, rdy_n_d;
   logic                    pg_n_q, pg_n_d;
   logic                    nc_q, nc_d;
   logic [1:0]              width_q, width_d;
   logic                    oe_q, oe_d;
   logic                    idle_q, idle_d;
   logic                    pv_d, pw_d, pb_d, pd_d;
   logic [27:0]             last_dram_q, last_dram_d;
   logic                    last_dram_v_q, last_dram_v_d;
   logic                    start;

   always_comb begin
      state_d       = state_q;
      gap_d         = gap_q;
      wait_d        = wait_q;
      psel_d        = psel_q;
      sel_n_d       = sel_n_q;
      lat_d         = lat_q;
      phit_d        = phit_q;
      busy_d        = busy_q;
      ack_d         = 1'b0;
      as_n_d        = 1'b1;
      rdy_n_d       = 1'b1;
      pg_n_d        = pg_n_q;
      nc_d          = nc_q;
      width_d       = width_q;
      oe_d          = oe_q;
      idle_d        = 1'b0;
      pv_d          = prev_valid_q;
      pw_d          = prev_write_q;
      pb_d          = prev_boot_q;
      pd_d          = prev_dram_q;
      last_dram_d   = last_dram_q;
      last_dram_v_d = last_dram_v_q;
      start         = 1'b0;
      unique case (state_q)
         CSD_ST_IDLE: begin
            if (bus_req.valid) begin
               lat_d   = bus_req;
               psel_d  = sel_c;
               wait_d  = waits_c;
               width_d = width_c;
               nc_d    = nc_c;
               busy_d  = 1'b1;
               // page hit is judged for the dram area alone
               phit_d  = sel_c[`CSD_SEL_DRAM] && last_dram_v_q &&
                         (((bus_req.addr ^ last_dram_q) & same_page_mask_setting)
                          == 28'h0);
               if (sel_c[`CSD_SEL_DRAM]) begin
                  last_dram_d   = bus_req.addr;
                  last_dram_v_d = 1'b1;
               end
               if (gap_c != 2'h0) begin
                  gap_d   = gap_c - 2'h1;
                  idle_d  = 1'b1;
                  state_d = CSD_ST_GAP;
               end else begin
                  start = 1'b1;
               end
            end else begin
               // a clock with no request breaks the back-to-back chain
               pv_d = 1'b0;
            end
         end
         CSD_ST_GAP: begin
            if (gap_q == 2'h0) begin
               start = 1'b1;
            end else begin
               gap_d  = gap_q - 2'h1;
               idle_d = 1'b1;
            end
         end
         CSD_ST_ACCESS: begin
            if (wait_q == 4'h0) begin
               rdy_n_d = 1'b0;
               ack_d   = 1'b1;
               busy_d  = 1'b0;
               sel_n_d = '1;
               oe_d    = 1'b0;
               pg_n_d  = 1'b1;
               pv_d    = 1'b1;
               pw_d    = lat_q.write;
               pb_d    = psel_q[`CSD_SEL_BOOT];
               pd_d    = psel_q[`CSD_SEL_DRAM];
               state_d = CSD_ST_IDLE;
            end else begin
               wait_d = wait_q - 4'h1;
            end
         end
      endcase
      if (start) begin
         // selects stay inactive until the idle cycles are spent
         sel_n_d = ~((state_q == CSD_ST_IDLE) ? sel_c : psel_q);
         as_n_d  = 1'b0;
         oe_d    = (state_q == CSD_ST_IDLE) ? bus_req.write : lat_q.write;
         pg_n_d  = ~((state_q == CSD_ST_IDLE) ? phit_d : phit_q);
         state_d = CSD_ST_ACCESS;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q       <= CSD_ST_IDLE;
         en_q          <= `CSD_ENABLE_RST;
         gap_q         <= 2'h0;
         wait_q        <= 4'h0;
         psel_q        <= '0;
         sel_n_q       <= '1;
         lat_q         <= '0;
         phit_q        <= 1'b0;
         busy_q        <= 1'b0;
         ack_q         <= 1'b0;
         as_n_q        <= 1'b1;
         rdy_n_q       <= 1'b1;
         pg_n_q        <= 1'b1;
         nc_q          <= 1'b0;
         width_q       <= `CSD_WIDTH_32;
         oe_q          <= 1'b0;
         idle_q        <= 1'b0;
         prev_valid_q  <= 1'b0;
         prev_write_q  <= 1'b0;
         prev_boot_q   <= 1'b0;
         prev_dram_q   <= 1'b0;
         last_dram_q   <= 28'h0;
         last_dram_v_q <= 1'b0;
      end else begin
         state_q       <= state_d;
         en_q          <= en_d;
         gap_q         <= gap_d;
         wait_q        <= wait_d;
         psel_q        <= psel_d;
         sel_n_q       <= sel_n_d;
         lat_q         <= lat_d;
         phit_q        <= phit_d;
         busy_q        <= busy_d;
         ack_q         <= ack_d;
         as_n_q        <= as_n_d;
         rdy_n_q       <= rdy_n_d;
         pg_n_q        <= pg_n_d;
         nc_q          <= nc_d;
         width_q       <= width_d;
         oe_q          <= oe_d;
         idle_q        <= idle_d;
         prev_valid_q  <= pv_d;
         prev_write_q  <= pw_d;
         prev_boot_q   <= pb_d;
         prev_dram_q   <= pd_d;
         last_dram_q   <= last_dram_d;
         last_dram_v_q <= last_dram_v_d;
      end
   end

   // ========================================================================
   // dram controller mode outputs
   logic       dctl_q, dctl_d;
   logic       dbst_q, dbst_d;
   logic       edo_q, edo_d;
   logic [3:0] cols_q, cols_d;

   always_comb begin
      dctl_d = dram_en;
      dbst_d = system_support_control[`CSD_SSC_BURST_EN];
      edo_d  = dram_edo_select && dbst_d;
      // codes past 4096 columns are clamped to the largest page
      cols_d = `CSD_PAGE_COL_BITS + ((dram_page_code > `CSD_PAGE_CODE_MAX) ?
               4'(`CSD_PAGE_CODE_MAX) : 4'(dram_page_code));
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dctl_q <= 1'b0;
         dbst_q <= 1'b0;
         edo_q  <= 1'b0;
         cols_q <= `CSD_PAGE_COL_BITS;
      end else begin
         dctl_q <= dctl_d;
         dbst_q <= dbst_d;
         edo_q  <= edo_d;
         cols_q <= cols_d;
      end
   end

   // ========================================================================
   // outputs, all from flip-flops
   assign bus_busy                     = busy_q;
   assign bus_ack                      = ack_q;
   assign boot_rom_select_n            = sel_n_q[`CSD_SEL_BOOT];
   assign general_select_a_n           = sel_n_q[`CSD_SEL_GEN_A];
   assign general_select_b_n           = sel_n_q[`CSD_SEL_GEN_B];
   assign peripheral_register_select_n = sel_n_q[`CSD_SEL_PERIPH];
   assign dram_select_n                = sel_n_q[`CSD_SEL_DRAM];
   assign noncacheable_area_select_n   = sel_n_q[`CSD_SEL_NONCACHE];
   assign bus_addr                     = lat_q.addr[27:2];
   assign address_strobe_n             = as_n_q;
   assign read_write_indicator         = lat_q.write;
   assign byte_enables_n               = ~lat_q.byte_en;
   assign ready_output_n               = rdy_n_q;
   assign data_out                     = lat_q.wdata;
   assign data_out_en                  = oe_q;
   assign page_hit_indication_n        = pg_n_q;
   assign cycle_noncacheable           = nc_q;
   assign cycle_width                  = width_q;
   assign idle_cycle_active            = idle_q;
   assign dram_ctrl_enable             = dctl_q;
   assign dram_burst_enable            = dbst_q;
   assign dram_edo_enable              = edo_q;
   assign dram_col_bits                = cols_q;

endmodule

// File: sim/csd_decoder_sva.sv
// concurrent checks on the chip-select decoder ports
`timescale 1ns/1ns
module csd_decoder_chk (
   input wire logic                  core_clk,
   input wire logic                  sys_rst,
   input wire csd_pkg::csd_bus_req_t bus_req,
   input wire logic                  bus_busy,
   input wire logic                  bus_ack,
   input wire logic [7:0]            system_support_control,
   input wire logic                  idle_insert_select_pin,
   input wire logic                  boot_rom_select_n,
   input wire logic                  general_select_a_n,
   input wire logic                  general_select_b_n,
   input wire logic                  peripheral_register_select_n,
   input wire logic                  dram_select_n,
   input wire logic                  noncacheable_area_select_n,
   input wire logic                  address_strobe_n,
   input wire logic                  read_write_indicator,
   input wire logic                  ready_output_n,
   input wire logic                  data_out_en,
   input wire logic                  page_hit_indication_n,
   input wire logic                  idle_cycle_active,
   input wire logic                  dram_ctrl_enable,
   input wire logic                  dram_burst_enable
);
   import csd_pkg::*;
   logic [5:0] sel_on;
   logic [1:0] pin_q;
   logic       boot_last_q;
   logic       pin_lo3;
   logic       pin_hi3;

   assign sel_on = ~{noncacheable_area_select_n, dram_select_n, peripheral_register_select_n,
                     general_select_b_n, general_select_a_n, boot_rom_select_n};
   // pin must sit steady long enough to pass the design's two-flop synchroniser
   assign pin_lo3 = !idle_insert_select_pin && !pin_q[0] && !pin_q[1];
   assign pin_hi3 = idle_insert_select_pin && pin_q[0] && pin_q[1];

   always_ff @(posedge core_clk) begin
      pin_q <= {pin_q[0], idle_insert_select_pin};
      if (sys_rst) begin
         boot_last_q <= 1'b0;
      end else if (!address_strobe_n) begin
         boot_last_q <= !boot_rom_select_n;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // ==========================================================================
   // assertions
   a_ready_with_ack: assert property (bus_ack == !ready_output_n)
      else $error("ready output and ack disagree");
   a_strobe_single: assert property (!address_strobe_n |-> bus_busy ##1 address_strobe_n)
      else $error("strobe outside access or longer than one cycle");
   a_write_data_out: assert property (!address_strobe_n && read_write_indicator |-> data_out_en)
      else $error("store data not driven during write");
   a_idle_no_select: assert property (idle_cycle_active |-> sel_on == 6'h00)
      else $error("select active in idle cycle");
   a_select_unique: assert property ($onehot0({sel_on[5] | sel_on[4], sel_on[3:0]}))
      else $error("more than one select active");
   a_release_quiet: assert property ($fell(sys_rst) |-> sel_on == 6'h00 && !bus_busy)
      else $error("selects not quiet after reset");
   a_ctrl_bits: assert property (!$past(sys_rst) |->
      {dram_burst_enable, dram_ctrl_enable} == $past(system_support_control[7:6]))
      else $error("dram enables do not follow control bits");
   a_read_write_gap: assert property (bus_ack && !read_write_indicator && bus_req.valid
      && bus_req.write && pin_lo3 |=> idle_cycle_active)
      else $error("no idle cycle for write after read");
   a_boot_gap_two: assert property ($rose(idle_cycle_active) && boot_last_q && pin_hi3
      |=> idle_cycle_active ##1 !idle_cycle_active)
      else $error("boot gap not two cycles");
   a_ack_bounded: assert property ($rose(bus_busy) |-> ##[1:18] bus_ack)
      else $error("access did not finish in time");

   c_write_done: cover property (bus_ack && read_write_indicator);
   c_idle_seen: cover property ($rose(idle_cycle_active));
   c_page_hit: cover property (!page_hit_indication_n && !dram_select_n);
endmodule

bind csd_decoder csd_decoder_chk i_csd_decoder_chk (.*);

// File: sim/csd_ext_devs.sv
// behavioural model of the external memories and peripherals
`timescale 1ns/1ns
module csd_ext_devs (
   input  wire logic        core_clk,
   input  wire logic [5:0]  sel_n,
   input  wire logic        address_strobe_n,
   input  wire logic        data_out_en,
   input  wire logic [31:0] data_out,
   input  wire logic        page_hit_indication_n,
   output logic [5:0]       seen_sel,
   output logic [31:0]      seen_data,
   output logic             seen_hit
);
   // devices latch on the strobe, as a real part would
   always @(posedge core_clk) begin
      if (!address_strobe_n) begin
         seen_sel <= ~sel_n;
         seen_hit <= page_hit_indication_n;
         if (data_out_en) begin
            seen_data <= data_out;
         end
      end
   end
endmodule

// File: sim/csd_decoder_tb_top.sv
// self-checking bench for the chip-select decoder
`timescale 1ns/1ns
`include "csd_regs.svh"
module csd_decoder_tb_top;
   import csd_pkg::*;
   logic         core_clk, sys_rst, sel_enable_load, noncache_function_en, dram_edo_select;
   logic         idle_insert_select_pin, bus_busy, bus_ack, address_strobe_n;
   logic         boot_rom_select_n, general_select_a_n, general_select_b_n, dram_select_n;
   logic         peripheral_register_select_n, noncacheable_area_select_n, read_write_indicator;
   logic         ready_output_n, data_out_en, page_hit_indication_n, cycle_noncacheable;
   logic         idle_cycle_active, dram_ctrl_enable, dram_burst_enable, dram_edo_enable;
   logic         seen_hit;
   logic [1:0]   cycle_width;
   logic [2:0]   dram_page_code;
   logic [3:0]   dram_col_bits, byte_enables_n;
   logic [27:2]  bus_addr;
   logic [5:0]   sel_enable, seen_sel;
   logic [7:0]   system_support_control;
   logic [27:0]  same_page_mask_setting;
   logic [31:0]  data_out, seen_data;
   csd_bus_req_t bus_req, nil;
   csd_sel_cfg_t sel_cfg [`CSD_NUM_SEL];
   int           err_total, comparisons, lat;

   csd_decoder i_csd_decoder (.*);
   csd_ext_devs i_csd_ext_devs (.core_clk, .address_strobe_n, .data_out_en, .data_out,
      .sel_n({noncacheable_area_select_n, dram_select_n, peripheral_register_select_n,
              general_select_b_n, general_select_a_n, boot_rom_select_n}),
      .page_hit_indication_n, .seen_sel, .seen_data, .seen_hit);

   // ==========================================================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic csd_bus_req_t mk(input logic [27:0] a, input logic w, input logic f);
      mk = '{1'b1, a, w, f, 4'hf, {4'ha, a}};
   endfunction

   // nx goes out while r is busy, so a valid nx is taken in r's ack cycle
   task automatic acc(input csd_bus_req_t r, input csd_bus_req_t nx, input int n, input logic [5:0] s);
      int g;
      if (bus_req !== r) begin
         @(posedge core_clk);
         bus_req <= r;
      end
      for (g = 0; g < 40 && bus_busy !== 1'b1; g++) begin
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      bus_req <= nx;
      #1;
      for (lat = 1; lat < 40 && bus_ack !== 1'b1; lat++) begin
         @(posedge core_clk);
         #1;
      end
      chk(lat, n);
      chk(seen_sel, s);
   endtask

   task automatic setc(input logic [7:0] ssc, input logic [2:0] pc, input logic pin);
      @(posedge core_clk);
      system_support_control <= ssc;
      dram_page_code <= pc;
      idle_insert_select_pin <= pin;
      repeat (4) @(posedge core_clk);
      #1;
   endtask

   task automatic final_report;
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==========================================================================
   // clock, watchdog, tests
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      final_report();
   end

   initial begin
      sys_rst = 1'b1;
      nil = '0;
      bus_req = '0;
      sel_enable = 6'h00;
      sel_enable_load = 1'b0;
      same_page_mask_setting = 28'hffff000;
      system_support_control = 8'h00;
      noncache_function_en = 1'b1;
      dram_page_code = 3'h4;
      dram_edo_select = 1'b1;
      idle_insert_select_pin = 1'b0;
      // settings fixed while in reset, areas kept apart apart from the dram overlap
      for (int i = 0; i < `CSD_NUM_SEL; i++) begin
         sel_cfg[i] = '{{i[3:0], 24'h000000}, 28'hff00000, `CSD_WIDTH_32, 1'b0, 4'h0};
      end
      sel_cfg[1].wait_en = 1'b1;
      sel_cfg[1].waits = 4'h3;
      sel_cfg[3] = '{28'h3000000, 28'hff00000, `CSD_WIDTH_8, 1'b1, 4'h1};
      sel_cfg[4].mask = 28'hf000000;
      sel_cfg[5] = '{28'h4800000, 28'hff00000, `CSD_WIDTH_8, 1'b0, 4'h0};
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      acc(mk(28'h0000000, 0, 1), nil, 1, 6'h01);
      acc(mk(28'h1000000, 0, 0), nil, 1, 6'h00);
      @(posedge core_clk);
      sel_enable <= 6'h3f;
      sel_enable_load <= 1'b1;
      @(posedge core_clk);
      sel_enable_load <= 1'b0;
      acc(mk(28'h1000000, 0, 0), nil, 4, 6'h02);
      acc(mk(28'h30003fc, 0, 0), nil, 2, 6'h08);
      chk(cycle_width, `CSD_WIDTH_16);
      acc(mk(28'h3000400, 0, 0), nil, 1, 6'h00);
      acc(mk(28'h3000010, 1, 0), nil, 2, 6'h08);
      chk(seen_data, 32'ha3000010);
      chk({bus_addr, byte_enables_n}, {26'h0c00004, 4'h0});
      acc(mk(28'h2000000, 0, 0), mk(28'h2000004, 1, 0), 1, 6'h04);
      acc(mk(28'h2000004, 1, 0), nil, 2, 6'h04);
      acc(mk(28'h2000000, 0, 0), nil, 1, 6'h04);
      acc(mk(28'h2000004, 1, 0), nil, 1, 6'h04);
      setc(8'hc0, 3'h4, 1'b0);
      chk({dram_burst_enable, dram_ctrl_enable, dram_edo_enable, dram_col_bits}, 7'h7c);
      acc(mk(28'h4000100, 0, 0), nil, 1, 6'h10);
      acc(mk(28'h4000104, 0, 0), nil, 1, 6'h10);
      chk(seen_hit, 1'b0);
      acc(mk(28'h4100000, 0, 0), nil, 1, 6'h10);
      chk(seen_hit, 1'b1);
      acc(mk(28'h2000000, 0, 0), nil, 1, 6'h04);
      chk(seen_hit, 1'b1);
      acc(mk(28'h4000200, 0, 1), mk(28'h4000204, 1, 0), 1, 6'h10);
      acc(mk(28'h4000204, 1, 0), mk(28'h4000208, 0, 0), 2, 6'h10);
      acc(mk(28'h4000208, 0, 0), mk(28'h400020c, 0, 1), 1, 6'h10);
      acc(mk(28'h400020c, 0, 1), nil, 1, 6'h10);
      acc(mk(28'h4800010, 0, 0), nil, 1, 6'h30);
      chk({cycle_noncacheable, cycle_width}, {1'b1, `CSD_WIDTH_32});
      setc(8'h00, 3'h0, 1'b1);
      chk({dram_burst_enable, dram_ctrl_enable, dram_edo_enable, dram_col_bits}, 7'h08);
      acc(mk(28'h4800010, 0, 0), nil, 1, 6'h30);
      chk(cycle_noncacheable, 1'b0);
      acc(mk(28'h0000010, 0, 0), mk(28'h2000000, 0, 0), 1, 6'h01);
      acc(mk(28'h2000000, 0, 0), nil, 3, 6'h04);
      acc(mk(28'h0000010, 0, 0), mk(28'h0000014, 0, 0), 1, 6'h01);
      acc(mk(28'h0000014, 0, 0), mk(28'h2000008, 0, 1), 1, 6'h01);
      acc(mk(28'h2000008, 0, 1), mk(28'h200000c, 1, 0), 1, 6'h04);
      acc(mk(28'h200000c, 1, 0), nil, 1, 6'h04);
      acc(mk(28'h4000300, 0, 0), mk(28'h4000304, 1, 0), 1, 6'h10);
      acc(mk(28'h4000304, 1, 0), nil, 2, 6'h10);
      final_report();
   end
endmodule
